/* pkg/supervisor_pkg.sv */
package supervisor_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS     = 8;
  // default internal oscillator period, nothing external programs it here
  localparam int SWITCH_PERIOD_NS  = 2000;
  localparam int SWITCH_PERIOD_CYC = SWITCH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DESYNC_DELAY_NS   = 16000;
  localparam int DESYNC_DELAY_CYC  =
    (DESYNC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFT_START_NS     = 1000000;
  localparam int SOFT_START_CYC    =
    (SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // field widths and reset values
  // ****************************************
  localparam int              DELAY_PROG_W     = 16;
  localparam int              REF_W            = 8;
  localparam logic [REF_W-1:0] REF_RESET       = 8'h00;
  localparam logic [REF_W-1:0] REF_FULL        = 8'hFF;
  // kick timeout ceiling in oscillator periods
  localparam logic [DELAY_PROG_W-1:0] KICK_TIMEOUT_CAP = 16'h0400;

  // ****************************************
  // state encodings
  // ****************************************
  typedef enum logic [2:0] {
    PWR_STANDBY    = 3'b000,
    PWR_LDO_UP     = 3'b001,
    PWR_SOFT_START = 3'b011,
    PWR_RUN        = 3'b010,
    PWR_LATCHED    = 3'b110
  } power_state_e;

  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_POR  = 2'b01,
    WD_BOOT = 2'b11,
    WD_KICK = 2'b10
  } watch_state_e;

endpackage

/* verilog/kick_edge_detect.sv */
module kick_edge_detect (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // raw kick level
  input  wire logic kick_input,
  // one-cycle pulse on a falling edge
  output logic      kick_fall
);

  logic kick_meta;
  logic kick_sync;
  logic kick_prev;

  // ****************************************
  // two-stage synchroniser, edge taken after it
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      kick_meta <= 1'b1;
      kick_sync <= 1'b1;
      kick_prev <= 1'b1;
      kick_fall <= 1'b0;
    end else if (clk_en) begin
      kick_meta <= kick_input; // RULE22
      kick_sync <= kick_meta;  // RULE22
      kick_prev <= kick_sync;
      kick_fall <= kick_prev & ~kick_sync;
    end
  end

endmodule // kick_edge_detect

/* verilog/switch_clock.sv */
module switch_clock #(
  parameter int PERIOD = supervisor_pkg::SWITCH_PERIOD_CYC,
  parameter int DESYNC = supervisor_pkg::DESYNC_DELAY_CYC
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // external synchronisation level
  input  wire logic sync_input,
  // switching period start and lock status
  output logic      tick,
  output logic      locked
);

  localparam int PW = $clog2(PERIOD);
  localparam int DW = $clog2(DESYNC);

  logic          sync_prev;
  logic [PW-1:0] period_cnt;
  logic [DW-1:0] desync_cnt;
  logic          sync_rise;

  if (PERIOD < 2 || DESYNC < 2) begin : g_check
    $error("switch_clock: PERIOD and DESYNC must be at least 2");
  end

  assign sync_rise = sync_input & ~sync_prev;

  // ****************************************
  // free-running period, overridden by sync edges
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_prev  <= 1'b0;
      period_cnt <= '0;
      desync_cnt <= '0;
      tick       <= 1'b0;
      locked     <= 1'b0;
    end else if (clk_en) begin
      sync_prev <= sync_input;
      if (sync_rise) begin
        // turn-on lands on the clock's rising edge
        tick       <= 1'b1; // RULE4
        locked     <= 1'b1;
        period_cnt <= '0;
        desync_cnt <= '0;
      end else begin
        tick <= ~locked && (period_cnt == PW'(PERIOD - 1));
        if (period_cnt == PW'(PERIOD - 1))
          period_cnt <= '0;
        else
          period_cnt <= period_cnt + 1'b1;
        if (locked) begin
          // a stuck level, high or low, drops back to the own period
          if (desync_cnt == DW'(DESYNC - 1)) begin
            locked     <= 1'b0; // RULE5
            period_cnt <= '0;
          end else begin
            desync_cnt <= desync_cnt + 1'b1;
          end
        end
      end
    end
  end

endmodule // switch_clock

/* verilog/regulator_watchdog_supervisor.sv */
// Behaviour
// RULE1 - soft-start waits for input start, enable high and one linear good
// RULE2 - linear good pulled low while gate regulator is below its stop level
// RULE3 - soft-start after enable, no faults, linear up; reference ramps
// RULE4 - with external sync, switch turn-on aligns to its rising edge
// RULE5 - stuck sync level returns to own frequency after desync delay
// RULE6 - sense below low threshold: reset low, all watchdog timers reinit
// RULE7 - sense above high threshold starts the power-on hold timer
// RULE8 - sense low after soft-start with enable low shuts device off
// RULE9 - switch turns off in any cycle when current exceeds limit
// RULE10 - sense short after soft-start latches off until enable toggles
// RULE11 - power-on hold starts in regulation, reset held low throughout
// RULE12 - hold expiry enters boot grace and releases reset
// RULE13 - after boot, each kick falling edge restarts the kick timeout
// RULE14 - timeout with enable high: reset low, hold again, outputs run
// RULE15 - timeout with enable low: reset low, all off, standby
// RULE16 - host kicks faster than the minimum kick timeout
// RULE17 - after faults clear, hold and boot run before kick watching
// RULE18 - kick timeout capped in oscillator periods for open resistor
// RULE19 - enable low ignored from linear good until soft-start ends
// RULE20 - overvoltage: reset low, no switching, soft-start reset, LDOs off
// RULE21 - enable low at start: standby, all off, reset low
// RULE22 - kick synchronised by two flops, delays counted in periods
// RULE23 - reset forced low by UVLO, overvoltage, heat or standby
module regulator_watchdog_supervisor #(
  parameter int SS_CYCLES     = supervisor_pkg::SOFT_START_CYC,
  parameter int SWITCH_PERIOD = supervisor_pkg::SWITCH_PERIOD_CYC,
  parameter int DESYNC_CYCLES = supervisor_pkg::DESYNC_DELAY_CYC,
  parameter int PROG_W        = supervisor_pkg::DELAY_PROG_W
) (
  // clock, reset, clock enable
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // input supply and die temperature comparators
  input  wire logic              vin_below_stop,
  input  wire logic              vin_above_start,
  input  wire logic              vin_over_stop,
  input  wire logic              over_temp,
  // enable comparators
  input  wire logic              enable_above_high,
  input  wire logic              enable_below_low,
  // linear regulator comparators
  input  wire logic              gate_regulator_above_start,
  input  wire logic              aux_regulator_above_start,
  input  wire logic              gate_regulator_below_stop,
  // converter output sense comparators
  input  wire logic              output_sense_below_low,
  input  wire logic              output_sense_above_high,
  input  wire logic              output_sense_short,
  // power switch feedback
  input  wire logic              switch_over_limit,
  input  wire logic              duty_end,
  // external clock, host kick, programmed delay
  input  wire logic              sync_input,
  input  wire logic              kick_input,
  input  wire logic [PROG_W-1:0] delay_program_resistor,
  // regulator controls
  output logic                   linear_enable,
  output logic                   switch_gate,
  output logic [supervisor_pkg::REF_W-1:0] soft_start_ref,
  output logic                   soft_start_done,
  output logic                   converter_latched,
  output logic                   sync_locked,
  // open-drain outputs, enable high while pulling low
  output logic                   reset_output_active_low,
  output logic                   reset_output_enable,
  output logic                   linear_good_output,
  output logic                   linear_good_enable
);

  localparam int SS_W  = $clog2(SS_CYCLES);
  localparam int REF_W = supervisor_pkg::REF_W;

  if (SS_CYCLES < 256 || PROG_W < 2) begin : g_check
    $error("supervisor: SS_CYCLES below 256 or PROG_W below 2");
  end

  // ****************************************
  // declarations
  // ****************************************
  supervisor_pkg::power_state_e power_state;
  supervisor_pkg::power_state_e next_power_state;
  supervisor_pkg::watch_state_e watch_state;

  logic              tick;
  logic              kick_fall;
  logic              fault;
  logic              linear_up;
  logic              switching_allowed;
  logic              watch_active;
  logic              kick_expired;
  logic              reset_pull;
  logic              linear_pull;
  logic              en_seen_low;
  logic [SS_W-1:0]   ss_count;
  logic              ss_expired;
  logic [PROG_W-1:0] watch_count;
  logic [PROG_W-1:0] kick_ticks;

  // ****************************************
  // helpers
  // ****************************************
  switch_clock #(
    .PERIOD (SWITCH_PERIOD),
    .DESYNC (DESYNC_CYCLES)
  ) u_switch_clock (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clk_en     (clk_en),
    .sync_input (sync_input),
    .tick       (tick),
    .locked     (sync_locked)
  );

  kick_edge_detect u_kick_edge (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clk_en     (clk_en),
    .kick_input (kick_input),
    .kick_fall  (kick_fall)
  );

  // ****************************************
  // condition terms
  // ****************************************
  assign fault      = vin_over_stop | over_temp;
  assign linear_up  = gate_regulator_above_start | aux_regulator_above_start;
  assign ss_expired = (ss_count == SS_W'(SS_CYCLES - 1));

  localparam logic [PROG_W-1:0] KICK_CAP =
    PROG_W'(supervisor_pkg::KICK_TIMEOUT_CAP);

  // an open resistor reads as a huge count; the ceiling bounds it
  assign kick_ticks = (delay_program_resistor > KICK_CAP) ?
                      KICK_CAP : delay_program_resistor; // RULE18

  assign switching_allowed = ~fault & ~vin_below_stop &
    ((power_state == supervisor_pkg::PWR_SOFT_START) |
     (power_state == supervisor_pkg::PWR_RUN)); // RULE20

  assign watch_active = switching_allowed & ~output_sense_below_low;

  assign kick_expired = (watch_state == supervisor_pkg::WD_KICK) &
                        tick & ~kick_fall & (watch_count == '0);

  // ****************************************
  // power sequencing
  // ****************************************
  always_comb begin
    next_power_state = power_state;
    case (power_state)
      supervisor_pkg::PWR_STANDBY: begin
        if (vin_above_start && enable_above_high)
          next_power_state = supervisor_pkg::PWR_LDO_UP;
      end
      supervisor_pkg::PWR_LDO_UP: begin
        if (!fault && linear_up && vin_above_start)
          next_power_state = supervisor_pkg::PWR_SOFT_START; // RULE1 RULE3
        else if (!fault && !linear_up && enable_below_low)
          next_power_state = supervisor_pkg::PWR_STANDBY; // RULE21
      end
      supervisor_pkg::PWR_SOFT_START: begin
        // enable is deliberately not looked at here
        if (fault)
          next_power_state = supervisor_pkg::PWR_LDO_UP; // RULE20
        else if (ss_expired)
          next_power_state = supervisor_pkg::PWR_RUN; // RULE19
      end
      supervisor_pkg::PWR_RUN: begin
        if (fault)
          next_power_state = supervisor_pkg::PWR_LDO_UP; // RULE20
        else if (output_sense_short)
          next_power_state = supervisor_pkg::PWR_LATCHED; // RULE10
        else if (enable_below_low && output_sense_below_low)
          next_power_state = supervisor_pkg::PWR_STANDBY; // RULE8
        else if (enable_below_low && kick_expired)
          next_power_state = supervisor_pkg::PWR_STANDBY; // RULE15
      end
      supervisor_pkg::PWR_LATCHED: begin
        if (en_seen_low && enable_above_high)
          next_power_state = supervisor_pkg::PWR_LDO_UP; // RULE10
      end
      default: next_power_state = supervisor_pkg::PWR_STANDBY;
    endcase
    // losing the input supply also clears the short-circuit latch
    if (vin_below_stop)
      next_power_state = supervisor_pkg::PWR_STANDBY; // RULE10
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      power_state <= supervisor_pkg::PWR_STANDBY;
    else if (clk_en)
      power_state <= next_power_state;
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      en_seen_low <= 1'b0;
    else if (clk_en) begin
      if (power_state != supervisor_pkg::PWR_LATCHED)
        en_seen_low <= 1'b0;
      else if (enable_below_low)
        en_seen_low <= 1'b1; // RULE10
    end
  end

  // ****************************************
  // soft-start
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ss_count       <= '0;
      soft_start_ref <= supervisor_pkg::REF_RESET;
    end else if (clk_en) begin
      if (power_state == supervisor_pkg::PWR_SOFT_START && !fault) begin
        if (!ss_expired)
          ss_count <= ss_count + 1'b1;
        soft_start_ref <= ss_count[SS_W-1 -: REF_W]; // RULE3
      end else if (power_state == supervisor_pkg::PWR_RUN) begin
        soft_start_ref <= supervisor_pkg::REF_FULL;
      end else begin
        ss_count       <= '0; // RULE20
        soft_start_ref <= supervisor_pkg::REF_RESET;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      soft_start_done   <= 1'b0;
      converter_latched <= 1'b0;
      linear_enable     <= 1'b0;
    end else if (clk_en) begin
      soft_start_done   <= (power_state == supervisor_pkg::PWR_RUN);
      converter_latched <= (power_state == supervisor_pkg::PWR_LATCHED);
      linear_enable     <= (power_state != supervisor_pkg::PWR_STANDBY) &
                           ~fault & ~vin_below_stop; // RULE20 RULE21
    end
  end

  // ****************************************
  // power switch
  // ****************************************
  // turn-off beats a period start landing in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst)
      switch_gate <= 1'b0;
    else if (clk_en) begin
      if (!switching_allowed || switch_over_limit || duty_end ||
          output_sense_short)
        switch_gate <= 1'b0; // RULE9
      else if (tick)
        switch_gate <= 1'b1; // RULE4
    end
  end

  // ****************************************
  // watchdog sequence, counted in oscillator periods
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      watch_state <= supervisor_pkg::WD_IDLE;
      watch_count <= '0;
    end else if (clk_en) begin
      if (!watch_active) begin
        watch_state <= supervisor_pkg::WD_IDLE; // RULE6 RULE17
        watch_count <= '0;
      end else begin
        case (watch_state)
          supervisor_pkg::WD_IDLE: begin
            if (output_sense_above_high) begin
              watch_state <= supervisor_pkg::WD_POR; // RULE7 RULE11
              watch_count <= delay_program_resistor;
            end
          end
          supervisor_pkg::WD_POR: begin
            if (tick) begin
              if (watch_count == '0) begin
                watch_state <= supervisor_pkg::WD_BOOT; // RULE12
                watch_count <= delay_program_resistor;
              end else
                watch_count <= watch_count - 1'b1; // RULE22
            end
          end
          supervisor_pkg::WD_BOOT: begin
            if (tick) begin
              if (watch_count == '0) begin
                watch_state <= supervisor_pkg::WD_KICK; // RULE13
                watch_count <= kick_ticks;
              end else
                watch_count <= watch_count - 1'b1;
            end
          end
          supervisor_pkg::WD_KICK: begin
            if (kick_fall)
              watch_count <= kick_ticks; // RULE13 RULE16
            else if (kick_expired) begin
              watch_state <= supervisor_pkg::WD_POR; // RULE14
              watch_count <= delay_program_resistor;
            end else if (tick)
              watch_count <= watch_count - 1'b1;
          end
          default: watch_state <= supervisor_pkg::WD_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // open-drain outputs
  // ****************************************
  assign reset_pull = vin_below_stop | fault |
    (power_state == supervisor_pkg::PWR_STANDBY) | // RULE23
    (watch_state == supervisor_pkg::WD_IDLE) |
    (watch_state == supervisor_pkg::WD_POR); // RULE11

  assign linear_pull = gate_regulator_below_stop | ~linear_enable; // RULE2

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_output_active_low <= 1'b0;
      reset_output_enable     <= 1'b1;
      linear_good_output      <= 1'b0;
      linear_good_enable      <= 1'b1;
    end else if (clk_en) begin
      reset_output_active_low <= ~reset_pull; // RULE6 RULE12
      reset_output_enable     <= reset_pull;  // RULE23
      linear_good_output      <= ~linear_pull;
      linear_good_enable      <= linear_pull; // RULE2
    end
  end

endmodule // regulator_watchdog_supervisor

/* bench/supervisor_asserts.sv */
module supervisor_checker #(
  parameter int REF_W = supervisor_pkg::REF_W
) (
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             rst,
  input wire logic             clk_en,
  // comparators
  input wire logic             vin_below_stop,
  input wire logic             vin_over_stop,
  input wire logic             over_temp,
  input wire logic             gate_regulator_below_stop,
  input wire logic             output_sense_below_low,
  input wire logic             switch_over_limit,
  // regulator controls
  input wire logic             linear_enable,
  input wire logic             switch_gate,
  input wire logic [REF_W-1:0] soft_start_ref,
  input wire logic             soft_start_done,
  input wire logic             converter_latched,
  // open-drain pins
  input wire logic             reset_output_active_low,
  input wire logic             reset_output_enable,
  input wire logic             linear_good_output,
  input wire logic             linear_good_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ****************************************
  // pins and faults
  // ****************************************
  a_reset_pin_pair: assert property (
    reset_output_active_low == !reset_output_enable)
    else $error("reset level and pull-down disagree");
  // four samples cover comparator, state and output register stages
  a_uvlo_heat_reset: assert property (
    ((vin_below_stop || over_temp) && clk_en)[*4]
    |-> reset_output_enable && !linear_enable)
    else $error("supply or heat fault left outputs on");
  a_overvolt_stop: assert property (
    (vin_over_stop && clk_en)[*4]
    |-> reset_output_enable && !linear_enable && !switch_gate)
    else $error("overvoltage left outputs on");
  a_gate_uv_good: assert property (
    (gate_regulator_below_stop && clk_en)[*4]
    |-> linear_good_enable && !linear_good_output)
    else $error("linear good not pulled low");
  a_sense_low_reset: assert property (
    (output_sense_below_low && clk_en)[*4] |-> reset_output_enable)
    else $error("reset released with sense low");

  // ****************************************
  // converter and sequencing
  // ****************************************
  a_limit_cuts_gate: assert property (
    switch_over_limit && clk_en |=> !switch_gate)
    else $error("switch on above current limit");
  a_done_full_ref: assert property (
    $rose(soft_start_done) |-> soft_start_ref == supervisor_pkg::REF_FULL)
    else $error("run entered before reference ramp ended");
  a_release_needs_ldo: assert property (
    $fell(reset_output_enable) |-> linear_enable)
    else $error("reset released with regulators off");
  a_latched_no_gate: assert property (
    converter_latched |-> !switch_gate)
    else $error("switching while latched off");
endmodule // supervisor_checker

bind regulator_watchdog_supervisor supervisor_checker supervisor_checker_i (
  .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
  .vin_below_stop(vin_below_stop), .vin_over_stop(vin_over_stop),
  .over_temp(over_temp),
  .gate_regulator_below_stop(gate_regulator_below_stop),
  .output_sense_below_low(output_sense_below_low),
  .switch_over_limit(switch_over_limit), .linear_enable(linear_enable),
  .switch_gate(switch_gate), .soft_start_ref(soft_start_ref),
  .soft_start_done(soft_start_done), .converter_latched(converter_latched),
  .reset_output_active_low(reset_output_active_low),
  .reset_output_enable(reset_output_enable),
  .linear_good_output(linear_good_output),
  .linear_good_enable(linear_good_enable)
);

/* bench/host_kick_model.sv */
module host_kick_model (
  // clock
  input  wire logic sys_clk,
  // firmware running, reset pin level
  input  wire logic run_kicks,
  input  wire logic reset_pin,
  // kick line
  output logic      kick_input
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned gap;

  // a host held in reset runs no firmware, so it cannot kick
  always @(negedge sys_clk) begin
    if (!run_kicks || !reset_pin) begin
      gap <= 0;
      kick_input <= 1'b1;
    end else begin
      gap <= (gap == 15) ? 0 : gap + 1;
      kick_input <= (gap >= 2);
    end
  end
endmodule // host_kick_model

/* bench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // stimulus and observed signals
  // ****************************************
  localparam logic [8:0] VBS = 9'h100, VAS = 9'h080, VOS = 9'h040;
  localparam logic [8:0] OT = 9'h020, EH = 9'h010, EL = 9'h008;
  localparam logic [8:0] UP = 9'h096, GBS = 9'h001;
  localparam int RST_EN = 0, LDO = 1, DONE = 2, LATCH = 3, LOCK = 4;
  localparam int GOOD = 5, GATE = 6;

  typedef struct {
    logic [8:0] in;
    logic       lin;
    logic       res;
  } row_s;

  logic        sys_clk, rst, clk_en, sense_lo, sense_hi;
  logic        short_in, over_lim, duty_end, sync_in;
  logic        kick, run_kicks, reset_pin;
  logic [8:0]  cmp;
  logic [15:0] prog;
  logic        linear_enable, switch_gate;
  logic        soft_start_done, converter_latched;
  logic        sync_locked, reset_output_active_low;
  logic        reset_output_enable, linear_good_output;
  logic        linear_good_enable;
  int          err_total, num_checks;

  logic [supervisor_pkg::REF_W-1:0] soft_start_ref;

  row_s rows [7] = '{
    '{VAS | EL, 1'b0, 1'b1},
    '{VAS | EH, 1'b1, 1'b1},
    '{UP, 1'b1, 1'b1},
    '{VAS | EH | VOS, 1'b0, 1'b1},
    '{VAS | EH | OT, 1'b0, 1'b1},
    '{VBS | VAS | EH, 1'b0, 1'b1},
    '{EH, 1'b0, 1'b1}
  };

  // open-drain reset with an external pull-up
  assign reset_pin = reset_output_enable ? 1'b0 : 1'b1;

  regulator_watchdog_supervisor #(
    .SS_CYCLES(256), .SWITCH_PERIOD(8), .DESYNC_CYCLES(40)
  ) regulator_watchdog_supervisor_i (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .vin_below_stop(cmp[8]), .vin_above_start(cmp[7]),
    .vin_over_stop(cmp[6]), .over_temp(cmp[5]),
    .enable_above_high(cmp[4]), .enable_below_low(cmp[3]),
    .gate_regulator_above_start(cmp[2]), .aux_regulator_above_start(cmp[1]),
    .gate_regulator_below_stop(cmp[0]),
    .output_sense_below_low(sense_lo), .output_sense_above_high(sense_hi),
    .output_sense_short(short_in), .switch_over_limit(over_lim),
    .duty_end(duty_end), .sync_input(sync_in), .kick_input(kick),
    .delay_program_resistor(prog), .linear_enable(linear_enable),
    .switch_gate(switch_gate), .soft_start_ref(soft_start_ref),
    .soft_start_done(soft_start_done), .converter_latched(converter_latched),
    .sync_locked(sync_locked),
    .reset_output_active_low(reset_output_active_low),
    .reset_output_enable(reset_output_enable),
    .linear_good_output(linear_good_output),
    .linear_good_enable(linear_good_enable)
  );

  host_kick_model host_kick_model_i (
    .sys_clk(sys_clk), .run_kicks(run_kicks), .reset_pin(reset_pin),
    .kick_input(kick)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  function automatic logic pick(input int k);
    case (k)
      RST_EN: return reset_output_enable;
      LDO: return linear_enable;
      DONE: return soft_start_done;
      LATCH: return converter_latched;
      LOCK: return sync_locked;
      GOOD: return linear_good_enable;
      default: return switch_gate;
    endcase
  endfunction

  task automatic wt(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    chk("output did not settle in time", pick(k), v);
  endtask

  task automatic bring_up();
    cmp = UP;
    sense_lo = 1'b1;
    sense_hi = 1'b0;
    repeat (3) @(negedge sys_clk);
    cmp = VAS | EL | 9'h006;
    repeat (125) @(negedge sys_clk);
    chk("ramp midway", soft_start_ref !== 8'h00 &&
        soft_start_ref !== supervisor_pkg::REF_FULL, 1'b1);
    cmp = UP;
    wt(DONE, 1'b1, 400);
    chk("reset with sense low", reset_output_enable, 1'b1);
    sense_lo = 1'b0;
    sense_hi = 1'b1;
    repeat (16) begin
      @(negedge sys_clk);
      chk("hold period", reset_output_enable, 1'b1);
    end
    wt(RST_EN, 1'b0, 60);
  endtask

  // ****************************************
  // clock, watchdog and main sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // whole run needs about 1700 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    summarize();
  end

  initial begin
    err_total = 0;
    num_checks = 0;
    {rst, clk_en, cmp, sense_lo, sense_hi} = {1'b1, 1'b1, 9'h000, 2'b10};
    {short_in, over_lim, duty_end, sync_in, run_kicks} = 5'b00000;
    prog = 16'h0003;
    repeat (10) @(negedge sys_clk);
    chk("reset value of reset", reset_output_enable, 1'b1);
    chk("reset value of good", linear_good_enable, 1'b1);
    foreach (rows[i]) begin
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      cmp = rows[i].in;
      repeat (6) @(negedge sys_clk);
      chk("row regulators", linear_enable, rows[i].lin);
      chk("row reset", reset_output_enable, rows[i].res);
    end
    bring_up();
    run_kicks = 1'b1;
    repeat (200) begin
      @(negedge sys_clk);
      chk("kicked reset", reset_output_enable, 1'b0);
    end
    run_kicks = 1'b0;
    wt(RST_EN, 1'b1, 80);
    chk("outputs kept", linear_enable, 1'b1);
    wt(RST_EN, 1'b0, 80);
    run_kicks = 1'b1;
    cmp = UP | GBS;
    repeat (5) @(negedge sys_clk);
    chk("good low", linear_good_enable, 1'b1);
    cmp = UP;
    wt(GOOD, 1'b0, 5);
    repeat (12) begin
      sync_in = 1'b1;
      repeat (3) @(negedge sys_clk);
      sync_in = 1'b0;
      repeat (3) @(negedge sys_clk);
    end
    chk("sync lock", sync_locked, 1'b1);
    wt(LOCK, 1'b0, 60);
    over_lim = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk("gate over limit", switch_gate, 1'b0);
    over_lim = 1'b0;
    wt(GATE, 1'b1, 40);
    short_in = 1'b1;
    wt(LATCH, 1'b1, 5);
    short_in = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk("latch holds", converter_latched, 1'b1);
    cmp = VAS | EL;
    repeat (3) @(negedge sys_clk);
    cmp = UP;
    wt(LATCH, 1'b0, 10);
    run_kicks = 1'b0;
    bring_up();
    cmp = UP | VOS;
    repeat (5) @(negedge sys_clk);
    chk("overvoltage reset", reset_output_enable, 1'b1);
    bring_up();
    cmp = VAS | EL | 9'h006;
    wt(LDO, 1'b0, 150);
    chk("standby reset", reset_output_enable, 1'b1);
    bring_up();
    cmp = VAS | EL | 9'h006;
    sense_lo = 1'b1;
    sense_hi = 1'b0;
    wt(LDO, 1'b0, 10);
    summarize();
  end
endmodule // tb_top
